// *** inc/txp_pkg.sv ***
// constants, carriers and state layout of the texture parameter tables
// assumes a single engine clock; commands arrive already decoded into fields
package txp_pkg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  localparam logic [7:0] TXP_GROUP_TABLES = 8'h03;
  localparam logic [7:0] TXP_SEL_LEVEL_BASE = 8'h10;
  localparam logic [7:0] TXP_SEL_FILTER = 8'h11;
  localparam logic [7:0] TXP_SEL_STIPPLE = 8'h14;
  localparam logic [7:0] TXP_SEL_READ_DEGAMMA = 8'h15;
  localparam logic [7:0] TXP_SEL_WRITE_DEGAMMA = 8'h17;

  // ----------------------------------------------------------------
  // table sizes
  // ----------------------------------------------------------------
  localparam int TXP_SAMPLES = 16;
  localparam int TXP_LEVELS = 8;
  localparam int TXP_BASE_ENTRIES = 128;
  localparam int TXP_FILT_ENTRIES = 32;
  localparam int TXP_RDG_ENTRIES = 5;
  localparam int TXP_WDG_ENTRIES = 6;
  localparam int TXP_RDG_POINTS = 15;
  localparam int TXP_BASE_W = 10;
  localparam int TXP_FILT_W = 22;
  localparam int TXP_DG_W = 30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TXP_LOC_HI = 31;
  localparam int TXP_LOC_LO = 30;
  localparam int TXP_OFS_HI = 7;
  localparam int TXP_OFS_LO = 0;
  localparam int TXP_OFS_SHIFT = 8;
  localparam int TXP_CM_HI = 21;
  localparam int TXP_CM_LO = 16;
  localparam int TXP_CRD_DBL = 15;
  localparam int TXP_CRD_HI = 14;
  localparam int TXP_CRD_LO = 8;
  localparam int TXP_CLU_DBL = 7;
  localparam int TXP_CLU_HI = 6;
  localparam int TXP_CLU_LO = 0;
  localparam int TXP_RND_HI = 31;
  localparam int TXP_RND_LO = 30;
  localparam int TXP_CURVE_BIT = 31;
  localparam int TXP_DG_HI = 29;
  localparam int TXP_VAL_W = 10;

  // ----------------------------------------------------------------
  // codes and special entries
  // ----------------------------------------------------------------
  localparam logic [1:0] TXP_RND_ROUND = 2'h1;
  localparam logic [7:0] TXP_RDG_RND_ENTRY = 8'h00;
  localparam logic [7:0] TXP_WDG_GRN_RND_ENTRY = 8'h01;
  localparam logic [7:0] TXP_WDG_BLU_RND_ENTRY = 8'h02;
  localparam logic [7:0] TXP_WDG_GRN_CURVE_ENTRY = 8'h04;
  localparam logic [7:0] TXP_WDG_BLU_CURVE_ENTRY = 8'h05;

  // ----------------------------------------------------------------
  // filter arithmetic
  // ----------------------------------------------------------------
  localparam int TXP_FRAC_BITS = 5;
  localparam logic [5:0] TXP_FIX_ONE = 6'h20;
  localparam int TXP_TEXEL_W = 8;
  localparam logic [7:0] TXP_TEXEL_MAX = 8'hff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] parameterGroupSelect;
    logic [7:0] parameterTableSelect;
    logic [7:0] tableEntryIndex;
    logic [31:0] data;
  } txp_wr_t;

  // quad 0..3, corner 0 up-left, 1 up-right, 2 down-left, 3 down-right
  typedef logic [3:0][3:0][7:0] txp_texels_t;

  // s2.5 two's complement for edge weights, u1.5 for middle weights
  typedef struct packed {
    logic [7:0] cl;
    logic [7:0] cr;
    logic [7:0] cu;
    logic [7:0] cd;
    logic [5:0] csm;
    logic [5:0] ctm;
  } txp_weights_t;

  typedef struct packed {
    logic [TXP_BASE_ENTRIES-1:0][TXP_BASE_W-1:0] base;
    logic [TXP_FILT_ENTRIES-1:0][TXP_FILT_W-1:0] filt;
    logic [31:0] stipple;
    logic [TXP_RDG_ENTRIES-1:0][TXP_DG_W-1:0] rdg;
    logic rdgRoundEn;
    logic [TXP_WDG_ENTRIES-1:0][TXP_DG_W-1:0] wdg;
    logic greenRoundEn;
    logic blueRoundEn;
    logic greenInverse;
    logic blueInverse;
    logic baseValid;
    logic [1:0] baseLoc;
    logic [15:0] baseOfs;
    logic filtValid;
    logic [7:0] filtPixel;
    txp_weights_t weights;
    logic rdgValid;
    logic [9:0] rdgValue;
    logic wdgValid;
    logic [9:0] wdgRed;
    logic [9:0] wdgGreen;
    logic [9:0] wdgBlue;
  } txp_state_t;

endpackage

// *** verilog/txp_filter4x4.sv ***
// combinational 4x4 filter: four bilinear quads blended by middle weights
// assumes weights already doubled; result truncated and clamped to a texel
`timescale 1ns/1ns
module txp_filter4x4 #(
  parameter int TEXEL_W = 8
) (
  // weights and texels
  input wire txp_pkg::txp_weights_t weights,
  input wire txp_pkg::txp_texels_t texels,
  // result
  output logic [7:0] pixel
);
  import txp_pkg::*;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  localparam logic signed [31:0] FIX_ONE = 32'(TXP_FIX_ONE);

  if (TEXEL_W != TXP_TEXEL_W) begin : g_check
    $error("txp_filter4x4: texel width must match the texel carrier");
  end

  function automatic logic signed [31:0] texel(input logic [7:0] t);
    return $signed({24'h000000, t});
  endfunction

  // 32 bits hold 1.5*1.5*255 at ten fraction bits with margin
  function automatic logic signed [31:0] bilerp(input logic signed [31:0] a, input logic signed [31:0] b,
                                                input logic [3:0][7:0] q);
    logic signed [31:0] na;
    logic signed [31:0] nb;
    logic signed [31:0] sum;
    na = FIX_ONE - a;
    nb = FIX_ONE - b;
    sum = na * nb * texel(q[0]) + a * nb * texel(q[1]) + na * b * texel(q[2]) + a * b * texel(q[3]);
    return sum >>> (2 * TXP_FRAC_BITS);
  endfunction

  logic signed [31:0] cl, cr, cu, cd, cs, ct;
  logic signed [31:0] t1, t2, t3, t4, acc;

  always_comb begin
    cl = 32'($signed(weights.cl));
    cr = 32'($signed(weights.cr));
    cu = 32'($signed(weights.cu));
    cd = 32'($signed(weights.cd));
    cs = 32'(weights.csm);
    ct = 32'(weights.ctm);
    t1 = bilerp(cl, cu, texels[0]);
    t2 = bilerp(cr, cu, texels[1]);
    t3 = bilerp(cl, cd, texels[2]);
    t4 = bilerp(cr, cd, texels[3]);
    acc = t1 * (FIX_ONE - cs) * (FIX_ONE - ct) + t2 * cs * (FIX_ONE - ct)
        + t3 * (FIX_ONE - cs) * ct + t4 * cs * ct;
    acc = acc >>> (2 * TXP_FRAC_BITS);
    if (acc < 0) begin
      pixel = 8'h00;
    end else if (acc > texel(TXP_TEXEL_MAX)) begin
      pixel = TXP_TEXEL_MAX;
    end else begin
      pixel = acc[7:0];
    end
  end

endmodule

// *** verilog/txp_param_tables.sv ***
// texture parameter tables: level bases, 4x4 filter, stipple, de-gamma
// assumes one write per cycle on the parameter path; lookups answer next cycle
`timescale 1ns/1ns
module txp_param_tables #(
  parameter int SAMPLES = 16,
  parameter int LEVELS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parameter command path
  input wire txp_pkg::txp_wr_t paramWr,
  // level base lookup
  input wire logic baseReq,
  input wire logic [3:0] baseSample,
  input wire logic [3:0] baseLevel,
  output logic baseValid,
  output logic [1:0] baseLocation,
  output logic [15:0] baseByteOffset,
  // filter
  input wire logic filtReq,
  input wire logic [4:0] fracS,
  input wire logic [4:0] fracT,
  input wire txp_pkg::txp_texels_t texels,
  output logic filtValid,
  output logic [7:0] filtPixel,
  output txp_pkg::txp_weights_t filtWeights,
  // texture-read de-gamma lookup
  input wire logic rdgReq,
  input wire logic [3:0] rdgPoint,
  output logic rdgValid,
  output logic [9:0] rdgValue,
  output logic rdgRoundEn,
  // colour-write de-gamma lookup
  input wire logic wdgReq,
  input wire logic [2:0] wdgEntry,
  output logic wdgValid,
  output logic [9:0] wdgRed,
  output logic [9:0] wdgGreen,
  output logic [9:0] wdgBlue,
  output logic greenRoundEn,
  output logic blueRoundEn,
  output logic greenInverseCurve,
  output logic blueInverseCurve,
  // stipple
  output logic [31:0] stipplePattern
);
  import txp_pkg::*;

  if (SAMPLES * LEVELS != TXP_BASE_ENTRIES || LEVELS != TXP_LEVELS || SAMPLES != TXP_SAMPLES) begin : g_check
    $error("txp_param_tables: base table shape is fixed at 16 samples by 8 levels");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] baseIndex(input logic [3:0] sample, input logic [3:0] level);
    logic [3:0] lm1;
    lm1 = level - 4'h1;
    return {sample, lm1[2:0]};
  endfunction

  function automatic logic [7:0] dblWeight(input logic [6:0] w, input logic dbl);
    return dbl ? {w, 1'b0} : {w[6], w};
  endfunction

  function automatic logic [5:0] clampMid(input logic [5:0] cm);
    return (cm > TXP_FIX_ONE) ? TXP_FIX_ONE : cm;
  endfunction

  function automatic logic [9:0] slot(input logic [TXP_DG_W-1:0] e, input logic [1:0] s);
    logic [9:0] v;
    v = e[TXP_VAL_W-1:0];
    if (s == 2'h1) begin
      v = e[2*TXP_VAL_W-1:TXP_VAL_W];
    end else if (s == 2'h2) begin
      v = e[TXP_DG_W-1:2*TXP_VAL_W];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  txp_state_t stateReg;
  txp_state_t stateNext;
  txp_weights_t weightsNow;
  logic [7:0] pixelNow;
  logic [TXP_FILT_W-1:0] filtS, filtT;
  logic groupHit;
  logic [7:0] idx;
  logic [3:0] pointEntry;
  logic [1:0] pointSlot;

  assign groupHit = paramWr.valid && paramWr.parameterGroupSelect == TXP_GROUP_TABLES;
  assign idx = paramWr.tableEntryIndex;
  assign filtS = stateReg.filt[fracS];
  assign filtT = stateReg.filt[fracT];
  assign pointEntry = rdgPoint / 4'h3;
  assign pointSlot = 2'(rdgPoint % 4'h3);

  // weights from the s entry go sideways, from the t entry up and down
  always_comb begin
    weightsNow.cl = dblWeight(filtS[TXP_CLU_HI:TXP_CLU_LO], filtS[TXP_CLU_DBL]);
    weightsNow.cr = dblWeight(filtS[TXP_CRD_HI:TXP_CRD_LO], filtS[TXP_CRD_DBL]);
    weightsNow.cu = dblWeight(filtT[TXP_CLU_HI:TXP_CLU_LO], filtT[TXP_CLU_DBL]);
    weightsNow.cd = dblWeight(filtT[TXP_CRD_HI:TXP_CRD_LO], filtT[TXP_CRD_DBL]);
    weightsNow.csm = filtS[TXP_CM_HI:TXP_CM_LO];
    weightsNow.ctm = filtT[TXP_CM_HI:TXP_CM_LO];
  end

  txp_filter4x4 #(
    .TEXEL_W(TXP_TEXEL_W)
  ) u_filter (
    .weights(weightsNow),
    .texels(texels),
    .pixel(pixelNow)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    // lookups read the table as it stood before a same-cycle write
    stateNext.baseValid = baseReq;
    if (baseReq) begin
      stateNext.baseLoc = 2'h0;
      stateNext.baseOfs = 16'h0000;
      if (baseLevel != 4'h0 && baseLevel <= 4'(TXP_LEVELS)) begin
        stateNext.baseLoc = stateReg.base[baseIndex(baseSample, baseLevel)][TXP_BASE_W-1:TXP_BASE_W-2];
        stateNext.baseOfs = {stateReg.base[baseIndex(baseSample, baseLevel)][7:0], 8'h00};
      end
    end
    stateNext.filtValid = filtReq;
    if (filtReq) begin
      stateNext.filtPixel = pixelNow;
      stateNext.weights = weightsNow;
    end
    stateNext.rdgValid = rdgReq;
    if (rdgReq) begin
      stateNext.rdgValue = 10'h000;
      if (rdgPoint < 4'(TXP_RDG_POINTS)) begin
        stateNext.rdgValue = slot(stateReg.rdg[pointEntry], pointSlot);
      end
    end
    stateNext.wdgValid = wdgReq;
    if (wdgReq) begin
      stateNext.wdgRed = 10'h000;
      stateNext.wdgGreen = 10'h000;
      stateNext.wdgBlue = 10'h000;
      if (wdgEntry < 3'(TXP_WDG_ENTRIES)) begin
        stateNext.wdgRed = slot(stateReg.wdg[wdgEntry], 2'h2);
        stateNext.wdgGreen = slot(stateReg.wdg[wdgEntry], 2'h1);
        stateNext.wdgBlue = slot(stateReg.wdg[wdgEntry], 2'h0);
      end
    end
    // writes keep only meaningful fields, so reserved bits never reach a result
    if (groupHit && paramWr.parameterTableSelect == TXP_SEL_LEVEL_BASE) begin
      if (idx < 8'(TXP_BASE_ENTRIES)) begin
        stateNext.base[idx[6:0]] = {paramWr.data[TXP_LOC_HI:TXP_LOC_LO],
                                    paramWr.data[TXP_OFS_HI:TXP_OFS_LO]};
      end
    end else if (groupHit && paramWr.parameterTableSelect == TXP_SEL_FILTER) begin
      if (idx < 8'(TXP_FILT_ENTRIES)) begin
        stateNext.filt[idx[4:0]] = {clampMid(paramWr.data[TXP_CM_HI:TXP_CM_LO]),
                                    paramWr.data[TXP_CRD_DBL:TXP_CLU_LO]};
      end
    end else if (groupHit && paramWr.parameterTableSelect == TXP_SEL_STIPPLE) begin
      stateNext.stipple = paramWr.data;
    end else if (groupHit && paramWr.parameterTableSelect == TXP_SEL_READ_DEGAMMA) begin
      if (idx < 8'(TXP_RDG_ENTRIES)) begin
        stateNext.rdg[idx[2:0]] = paramWr.data[TXP_DG_HI:0];
      end
      if (idx == TXP_RDG_RND_ENTRY) begin
        stateNext.rdgRoundEn = paramWr.data[TXP_RND_HI:TXP_RND_LO] == TXP_RND_ROUND;
      end
    end else if (groupHit && paramWr.parameterTableSelect == TXP_SEL_WRITE_DEGAMMA) begin
      if (idx < 8'(TXP_WDG_ENTRIES)) begin
        stateNext.wdg[idx[2:0]] = paramWr.data[TXP_DG_HI:0];
      end
      if (idx == TXP_WDG_GRN_RND_ENTRY) begin
        stateNext.greenRoundEn = paramWr.data[TXP_RND_HI:TXP_RND_LO] == TXP_RND_ROUND;
      end else if (idx == TXP_WDG_BLU_RND_ENTRY) begin
        stateNext.blueRoundEn = paramWr.data[TXP_RND_HI:TXP_RND_LO] == TXP_RND_ROUND;
      end else if (idx == TXP_WDG_GRN_CURVE_ENTRY) begin
        stateNext.greenInverse = paramWr.data[TXP_CURVE_BIT];
      end else if (idx == TXP_WDG_BLU_CURVE_ENTRY) begin
        stateNext.blueInverse = paramWr.data[TXP_CURVE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign baseValid = stateReg.baseValid;
  assign baseLocation = stateReg.baseLoc;
  assign baseByteOffset = stateReg.baseOfs;
  assign filtValid = stateReg.filtValid;
  assign filtPixel = stateReg.filtPixel;
  assign filtWeights = stateReg.weights;
  assign rdgValid = stateReg.rdgValid;
  assign rdgValue = stateReg.rdgValue;
  assign rdgRoundEn = stateReg.rdgRoundEn;
  assign wdgValid = stateReg.wdgValid;
  assign wdgRed = stateReg.wdgRed;
  assign wdgGreen = stateReg.wdgGreen;
  assign wdgBlue = stateReg.wdgBlue;
  assign greenRoundEn = stateReg.greenRoundEn;
  assign blueRoundEn = stateReg.blueRoundEn;
  assign greenInverseCurve = stateReg.greenInverse;
  assign blueInverseCurve = stateReg.blueInverse;
  assign stipplePattern = stateReg.stipple;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TXP_BASE_W-1:0] baseLast, base9;
  logic [TXP_DG_W-1:0] wdg1, rdg1;
  logic [5:0] cmS;
  assign baseLast = stateReg.base[TXP_BASE_ENTRIES-1];
  assign base9 = stateReg.base[9];
  assign wdg1 = stateReg.wdg[1];
  assign rdg1 = stateReg.rdg[1];
  assign cmS = filtS[TXP_CM_HI:TXP_CM_LO];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_base_write_last;
    groupHit && paramWr.parameterTableSelect == TXP_SEL_LEVEL_BASE && idx == 8'h7f;
  endsequence
  sequence s_stipple_write;
    groupHit && paramWr.parameterTableSelect == TXP_SEL_STIPPLE;
  endsequence
  sequence s_rdg_reserved_rnd;
    groupHit && paramWr.parameterTableSelect == TXP_SEL_READ_DEGAMMA && idx == TXP_RDG_RND_ENTRY
      && paramWr.data[TXP_RND_HI];
  endsequence
  sequence s_wdg_write_two;
    groupHit && paramWr.parameterTableSelect == TXP_SEL_WRITE_DEGAMMA && idx == TXP_WDG_BLU_RND_ENTRY;
  endsequence

  a_base_last_entry: assert property (s_base_write_last
    |=> baseLast == {$past(paramWr.data[TXP_LOC_HI:TXP_LOC_LO]), $past(paramWr.data[TXP_OFS_HI:TXP_OFS_LO])})
    else $error("last base entry not written");
  a_base_index_map: assert property (baseReq && baseSample == 4'h1 && baseLevel == 4'h2
    |=> baseLocation == $past(base9[9:8]) && baseByteOffset == {$past(base9[7:0]), 8'h00})
    else $error("base index map wrong");
  a_base_align: assert property (baseValid |-> baseByteOffset[7:0] == 8'h00)
    else $error("level base not on 256-byte boundary");
  a_filt_mid_pick: assert property (filtReq |=> filtValid && filtWeights.csm == $past(cmS))
    else $error("middle weight not taken from s entry");
  a_mid_limit: assert property (filtValid
    |-> filtWeights.csm <= TXP_FIX_ONE && filtWeights.ctm <= TXP_FIX_ONE)
    else $error("middle weight above one");
  a_crd_double: assert property (filtReq && filtS[TXP_CRD_DBL]
    |=> filtWeights.cr == {$past(filtS[TXP_CRD_HI:TXP_CRD_LO]), 1'b0})
    else $error("right weight not doubled");
  a_clu_double: assert property (filtReq && filtT[TXP_CLU_DBL]
    |=> filtWeights.cu == {$past(filtT[TXP_CLU_HI:TXP_CLU_LO]), 1'b0})
    else $error("up weight not doubled");
  a_stipple_word: assert property (s_stipple_write |=> stipplePattern == $past(paramWr.data))
    else $error("stipple word not stored");
  a_rnd_reserved: assert property (s_rdg_reserved_rnd |=> !rdgRoundEn)
    else $error("reserved rounding not truncation");
  a_wdg_isolated: assert property (s_wdg_write_two |=> $stable(wdg1))
    else $error("write touched neighbouring entry");
  a_rdg_point_map: assert property (rdgReq && rdgPoint == 4'h5
    |=> rdgValue == $past(rdg1[TXP_DG_HI:2*TXP_VAL_W]))
    else $error("read de-gamma point map wrong");
  a_wdg_channel_split: assert property (wdgReq && wdgEntry == 3'h1
    |=> wdgRed == $past(wdg1[TXP_DG_HI:2*TXP_VAL_W]) && wdgGreen == $past(wdg1[2*TXP_VAL_W-1:TXP_VAL_W])
      && wdgBlue == $past(wdg1[TXP_VAL_W-1:0]))
    else $error("write de-gamma channels swapped");

endmodule

// *** sim/txp_param_tables_tb.sv ***
// self-checking bench for the texture parameter tables
// assumes lookups answer one cycle after the request edge and writes land within two edges
`timescale 1ns/1ns
module txp_param_tables_tb;
  import txp_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] idx;
    logic [31:0] data;
    logic [2:0] kind;
    logic [4:0] a;
    logic [4:0] b;
    logic [31:0] wantVal;
  } txp_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  txp_wr_t paramWr = '0;
  logic baseReq = 1'b0;
  logic [3:0] baseSample = 4'h0;
  logic [3:0] baseLevel = 4'h0;
  logic filtReq = 1'b0;
  logic [4:0] fracS = 5'h00;
  logic [4:0] fracT = 5'h00;
  txp_texels_t texels = '0;
  logic rdgReq = 1'b0;
  logic [3:0] rdgPoint = 4'h0;
  logic wdgReq = 1'b0;
  logic [2:0] wdgEntry = 3'h0;
  logic baseValid, filtValid, rdgValid, wdgValid, rdgRoundEn, greenRoundEn, blueRoundEn;
  logic greenInverseCurve, blueInverseCurve;
  logic [1:0] baseLocation;
  logic [15:0] baseByteOffset;
  logic [7:0] filtPixel;
  txp_weights_t filtWeights;
  logic [9:0] rdgValue, wdgRed, wdgGreen, wdgBlue;
  logic [31:0] stipplePattern;
  int miscompares = 0;
  int checked = 0;
  txp_row_t rows [8];

  always #20 clk = ~clk;

  txp_param_tables dut_u (.clk(clk), .rst_n(rst_n), .paramWr(paramWr), .baseReq(baseReq),
    .baseSample(baseSample), .baseLevel(baseLevel), .baseValid(baseValid), .baseLocation(baseLocation),
    .baseByteOffset(baseByteOffset), .filtReq(filtReq), .fracS(fracS), .fracT(fracT), .texels(texels),
    .filtValid(filtValid), .filtPixel(filtPixel), .filtWeights(filtWeights), .rdgReq(rdgReq),
    .rdgPoint(rdgPoint), .rdgValid(rdgValid), .rdgValue(rdgValue), .rdgRoundEn(rdgRoundEn), .wdgReq(wdgReq),
    .wdgEntry(wdgEntry), .wdgValid(wdgValid), .wdgRed(wdgRed), .wdgGreen(wdgGreen), .wdgBlue(wdgBlue),
    .greenRoundEn(greenRoundEn), .blueRoundEn(blueRoundEn), .greenInverseCurve(greenInverseCurve),
    .blueInverseCurve(blueInverseCurve), .stipplePattern(stipplePattern));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [44:0] got, input logic [44:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one strobe cycle, then an idle edge so the stored value has landed
  task automatic wr(input logic [7:0] grp, input logic [7:0] sel, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    paramWr <= '{1'b1, grp, sel, idx, d};
    @(posedge clk);
    paramWr.valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // kind: 0 base, 1 read de-gamma, 2 write de-gamma, 3 stipple, 4 filter
  task automatic look(input logic [2:0] k, input logic [4:0] a, input logic [4:0] b);
    @(posedge clk);
    case (k)
      3'h0: begin baseReq <= 1'b1; baseSample <= a[3:0]; baseLevel <= b[3:0]; end
      3'h1: begin rdgReq <= 1'b1; rdgPoint <= a[3:0]; end
      3'h2: begin wdgReq <= 1'b1; wdgEntry <= a[2:0]; end
      3'h4: begin filtReq <= 1'b1; fracS <= a; fracT <= b; end
      default: ;
    endcase
    @(posedge clk);
    baseReq <= 1'b0;
    rdgReq <= 1'b0;
    wdgReq <= 1'b0;
    filtReq <= 1'b0;
    #1;
  endtask

  function automatic logic [44:0] res(input logic [2:0] k);
    case (k)
      3'h0: return {baseValid, 26'h0, baseLocation, baseByteOffset};
      3'h1: return {rdgValid, 34'h0, rdgValue};
      3'h2: return {wdgValid, 14'h0, wdgRed, wdgGreen, wdgBlue};
      default: return {1'b1, 12'h0, stipplePattern};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{TXP_SEL_LEVEL_BASE, 8'h09, 32'h40ff_33a5, 3'h0, 5'h01, 5'h02, 32'h0001_a500};
    rows[1] = '{TXP_SEL_LEVEL_BASE, 8'h7f, 32'hc000_0001, 3'h0, 5'h0f, 5'h08, 32'h0003_0100};
    rows[2] = '{TXP_SEL_LEVEL_BASE, 8'h00, 32'h8000_00ff, 3'h0, 5'h00, 5'h01, 32'h0002_ff00};
    rows[3] = '{TXP_SEL_READ_DEGAMMA, 8'h01, 32'hfa1a_c9c3, 3'h1, 5'h05, 5'h00, 32'h0000_03a1};
    rows[4] = '{TXP_SEL_READ_DEGAMMA, 8'h04, 32'h0000_0155, 3'h1, 5'h0c, 5'h00, 32'h0000_0155};
    rows[5] = '{TXP_SEL_WRITE_DEGAMMA, 8'h02, 32'h5238_d345, 3'h2, 5'h02, 5'h00, 32'h1238_d345};
    rows[6] = '{TXP_SEL_WRITE_DEGAMMA, 8'h01, 32'h8fff_ffff, 3'h2, 5'h01, 5'h00, 32'h0fff_ffff};
    rows[7] = '{TXP_SEL_STIPPLE, 8'h33, 32'h9c3e_5a71, 3'h3, 5'h00, 5'h00, 32'h9c3e_5a71};
    repeat (8) @(posedge clk);
    chk({1'b0, baseValid, filtValid, rdgValid, wdgValid, stipplePattern, filtPixel}, 45'h0);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(TXP_GROUP_TABLES, rows[i].sel, rows[i].idx, rows[i].data);
      look(rows[i].kind, rows[i].a, rows[i].b);
      chk(res(rows[i].kind), {1'b1, 12'h0, rows[i].wantVal});
    end
    // rounding codes, the two reserved ones must act as truncate
    for (int e = 0; e < 3; e++) begin
      for (int c = 0; c < 4; c++) begin
        wr(TXP_GROUP_TABLES, (e == 0) ? TXP_SEL_READ_DEGAMMA : TXP_SEL_WRITE_DEGAMMA, 8'(e), {2'(c), 30'h0});
        chk({44'h0, (e == 0) ? rdgRoundEn : (e == 1) ? greenRoundEn : blueRoundEn}, {44'h0, c == 1});
      end
    end
    wr(TXP_GROUP_TABLES, TXP_SEL_WRITE_DEGAMMA, 8'h04, 32'h8000_0000);
    wr(TXP_GROUP_TABLES, TXP_SEL_WRITE_DEGAMMA, 8'h05, 32'h8000_0000);
    chk({43'h0, greenInverseCurve, blueInverseCurve}, 45'h3);
    wr(TXP_GROUP_TABLES, TXP_SEL_WRITE_DEGAMMA, 8'h04, 32'h0000_0000);
    chk({43'h0, greenInverseCurve, blueInverseCurve}, 45'h1);
    // filter: all edge weights doubled, half middle weights, corner-graded quads
    @(posedge clk);
    for (int q = 0; q < 4; q++)
      for (int c = 0; c < 4; c++)
        texels[q][c] <= 8'(q * 40 + c * 8);
    wr(TXP_GROUP_TABLES, TXP_SEL_FILTER, 8'h03, 32'h0010_8888);
    look(3'h4, 5'h03, 5'h03);
    chk({filtValid, filtWeights}, {1'b1, 8'h10, 8'h10, 8'h10, 8'h10, 6'h10, 6'h10});
    chk({filtValid, 36'h0, filtPixel}, {1'b1, 36'h0, 8'h48});
    // clamped middle weight, negative up weight, doubled down weight, reserved bit
    @(posedge clk);
    texels <= {16{8'h32}};
    wr(TXP_GROUP_TABLES, TXP_SEL_FILTER, 8'h1f, 32'h803f_0102);
    wr(TXP_GROUP_TABLES, TXP_SEL_FILTER, 8'h00, 32'h0000_a070);
    look(3'h4, 5'h1f, 5'h00);
    chk({filtValid, filtWeights}, {1'b1, 8'h02, 8'h01, 8'hf0, 8'h40, 6'h20, 6'h00});
    chk({filtValid, 36'h0, filtPixel}, {1'b1, 36'h0, 8'h32});
    // refused writes: foreign group, index past the table; then out-of-range level and point lookups
    wr(8'h02, TXP_SEL_STIPPLE, 8'h00, 32'h0000_0001);
    chk(res(3'h3), {13'h1000, 32'h9c3e_5a71});
    wr(TXP_GROUP_TABLES, TXP_SEL_LEVEL_BASE, 8'h80, 32'h4000_0077);
    look(3'h0, 5'h00, 5'h01);
    chk(res(3'h0), {1'b1, 26'h0, 18'h2ff00});
    look(3'h0, 5'h01, 5'h09);
    chk(res(3'h0), {1'b1, 44'h0});
    look(3'h1, 5'h0f, 5'h00);
    chk(res(3'h1), {1'b1, 44'h0});
    // second reset in mid-run clears tables and levels
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({11'h0, blueInverseCurve, stipplePattern, baseValid}, 45'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    look(3'h0, 5'h01, 5'h02);
    chk(res(3'h0), {1'b1, 44'h0});
    end_sim;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule
